// File: cfg_regs.vh
// constants for the config word store, its field layout and the serial programming link
`ifndef CFG_REGS_VH
`define CFG_REGS_VH

// ==========================================================
// timing
`define SYS_CLK_NS          40
`define READY_LOW_NS        15000
`define READY_LOW_CYC       (`READY_LOW_NS / `SYS_CLK_NS)
`define BUSY_MIN_CYC        4

// ==========================================================
// config word values and field positions
`define CW_ERASED           16'hFFFF
`define CW1_DBG_PAIR_HI     9
`define CW1_DBG_PAIR_LO     8
`define CW1_WDOG_DIV_BIT    4
`define CW1_WDOG_WDOG_WINDOW_DISABLE_BIT 6
`define CW1_WDOG_ALWAYS_BIT 7
`define CW1_WR_PROT_BIT     12
`define CW1_RD_PROT_BIT     13
`define CW2_POSC_HI         1
`define CW2_POSC_LO         0
`define CW2_REMAP_ONCE_BIT  4
`define CW2_OSC_FN_BIT      5
`define CW2_SOSC_HI         12
`define CW2_SOSC_LO         11
`define CW2_WAKE_HI         14
`define CW2_WAKE_LO         13
`define CW2_TWO_SPEED_BIT   15

// ==========================================================
// command opcodes, response status codes, config addresses
`define OP_SANITY           4'h0
`define OP_MEM_READ         4'h2
`define OP_ROW_PROG         4'h5
`define OP_CFG_WRITE        4'h6
`define RSP_PASS            4'h1
`define RSP_FAIL            4'h2
`define RSP_NACK            4'h3
`define CFG1_ADDR           16'hFFFE
`define CFG2_ADDR           16'hFFFF
`define CFG_HI_BYTE_BIT     8

`endif

// File: cfg_fields.v
// decode of the active config words into control levels, plus the pin-remap lock
`timescale 1ns/1ps
`include "cfg_regs.vh"

module cfg_fields (
    input  wire        clk,
    input  wire        rst_i_n,
    input  wire [15:0] cw1,
    input  wire [15:0] cw2,
    input  wire        remap_unlocked,
    input  wire        remap_lock_set,
    input  wire        remap_lock_clear,
    output wire [2:0]  emulation_pin_pair,
    output wire        dbg_pair_reserved,
    output wire        two_speed_startup_en,
    output wire        osc_pin_clock_out,
    output wire        osc_pin_gpio,
    output wire        sec_osc_high_drive,
    output wire        sec_osc_low_power,
    output wire        sec_osc_reserved,
    output wire [3:0]  primary_osc_mode,
    output wire        wdog_div_128,
    output wire        wdog_window_mode,
    output wire        wdog_window_invalid,
    output wire        regulator_fast_wake,
    output wire        regulator_wake_reserved,
    output wire        remap_locked,
    output wire        remap_write_en
);
    // ==========================================================
    // field decode
    reg remap_lock_q;
    reg remap_lock_d;
    wire [1:0] dbg   = cw1[`CW1_DBG_PAIR_HI:`CW1_DBG_PAIR_LO];
    wire [1:0] posc  = cw2[`CW2_POSC_HI:`CW2_POSC_LO];
    wire [1:0] sosc  = cw2[`CW2_SOSC_HI:`CW2_SOSC_LO];
    wire [1:0] wake  = cw2[`CW2_WAKE_HI:`CW2_WAKE_LO];
    wire       xtal  = (posc == 2'b10) | (posc == 2'b01);

    // pair 1 on 11, pair 2 on 10, pair 3 on 01; 00 routes nowhere
    assign emulation_pin_pair = {dbg == 2'b01, dbg == 2'b10, dbg == 2'b11};
    assign dbg_pair_reserved  = (dbg == 2'b00);
    assign two_speed_startup_en = cw2[`CW2_TWO_SPEED_BIT];
    // crystal modes own the pin, so the function bit is ignored there
    assign osc_pin_clock_out  = cw2[`CW2_OSC_FN_BIT] & ~xtal;
    assign osc_pin_gpio       = ~cw2[`CW2_OSC_FN_BIT] & ~xtal;
    assign sec_osc_high_drive = (sosc == 2'b11);
    assign sec_osc_low_power  = (sosc == 2'b01);
    assign sec_osc_reserved   = ~sosc[0];
    // one-hot: {disabled, high speed crystal, standard crystal, external clock}
    assign primary_osc_mode   = {posc == 2'b11, posc == 2'b10, posc == 2'b01, posc == 2'b00};
    assign wdog_div_128       = cw1[`CW1_WDOG_DIV_BIT];
    assign wdog_window_mode   = ~cw1[`CW1_WDOG_WDOG_WINDOW_DISABLE_BIT] & cw1[`CW1_WDOG_ALWAYS_BIT];
    assign wdog_window_invalid = ~cw1[`CW1_WDOG_WDOG_WINDOW_DISABLE_BIT] & ~cw1[`CW1_WDOG_ALWAYS_BIT];
    assign regulator_fast_wake = (wake == 2'b01);
    assign regulator_wake_reserved = ~wake[0];

    // ==========================================================
    // pin-remap lock; set wins over clear in the same cycle
    always @* begin
        remap_lock_d = remap_lock_q;
        if (remap_unlocked & remap_lock_clear & ~cw2[`CW2_REMAP_ONCE_BIT])
            remap_lock_d = 1'b0;
        if (remap_unlocked & remap_lock_set)
            remap_lock_d = 1'b1;
    end

    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n)
            remap_lock_q <= 1'b0;
        else
            remap_lock_q <= remap_lock_d;
    end

    assign remap_locked   = remap_lock_q;
    assign remap_write_en = ~remap_lock_q;
endmodule // cfg_fields

// File: prog_exec.v
// programming executive: serial command link, config word store, code protection
`timescale 1ns/1ps
`include "cfg_regs.vh"
// Operation
// - debug pair field routes emulation pins
// - bit 15 enables two-speed start-up
// - one-shot bit makes remap lock permanent
// - osc pin: clock out or gpio
// - secondary oscillator drive strength select
// - primary oscillator mode select
// - watchdog divider 1:128 or 1:32
// - watchdog window mode needs always-on
// - regulator wake time select
// - cw1 bits 12/13 protect, active low
// - erase sets both protect bits to one
// - write protect makes code programming fail
// - read protect returns zero, programming fails
// - only low-level bulk erase releases protection
// - one command in, one response out
// - input held at falling, output changes falling
// - sixteen-bit words, msb first
// - busy high, then ready low pulse
// - header: 4-bit opcode, 12-bit length

module prog_exec (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        nv_por_n,
    input  wire        master_clear_pin,
    input  wire        prog_clock_pin,
    input  wire        prog_data_in,
    output wire        prog_data_out,
    output wire        prog_data_oe,
    input  wire        low_level_mode,
    input  wire        bulk_erase_req,
    output wire [15:0] mem_addr,
    output wire [15:0] mem_wdata,
    output wire        mem_we,
    input  wire [15:0] mem_rdata,
    input  wire        remap_unlocked,
    input  wire        remap_lock_set,
    input  wire        remap_lock_clear,
    output wire [15:0] config_word_one,
    output wire [15:0] config_word_two,
    output wire [2:0]  emulation_pin_pair,
    output wire        dbg_pair_reserved,
    output wire        two_speed_startup_en,
    output wire        osc_pin_clock_out,
    output wire        osc_pin_gpio,
    output wire        sec_osc_high_drive,
    output wire        sec_osc_low_power,
    output wire        sec_osc_reserved,
    output wire [3:0]  primary_osc_mode,
    output wire        wdog_div_128,
    output wire        wdog_window_mode,
    output wire        wdog_window_invalid,
    output wire        regulator_fast_wake,
    output wire        regulator_wake_reserved,
    output wire        remap_locked,
    output wire        remap_write_en
);
    // ==========================================================
    // states and timing
    localparam [3:0] ST_RX    = 4'h1;
    localparam [3:0] ST_BUSY  = 4'h2;
    localparam [3:0] ST_READY = 4'h4;
    localparam [3:0] ST_TX    = 4'h8;
    localparam [15:0] READY_CYC = `READY_LOW_CYC;
    localparam [15:0] BUSY_CYC  = `BUSY_MIN_CYC;

    // ==========================================================
    // reset release and pin synchronisers
    reg rst_s1, rst_i_n, nv_s1, nv_i_n;
    reg pgc_s1, pgc_s2, pgc_s3, pgd_s1, pgd_s2;
    reg master_clear_pin_s1, master_clear_pin_s2, erq_s1, erq_s2, erq_s3, llm_s1, llm_s2;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1  <= 1'b0;
            rst_i_n <= 1'b0;
        end else begin
            rst_s1  <= 1'b1;
            rst_i_n <= rst_s1;
        end
    end

    // the store has its own power-on reset so a core reset keeps it
    always @(posedge sys_clk or negedge nv_por_n) begin
        if (!nv_por_n) begin
            nv_s1  <= 1'b0;
            nv_i_n <= 1'b0;
        end else begin
            nv_s1  <= 1'b1;
            nv_i_n <= nv_s1;
        end
    end

    // clock and data share the same two-stage delay, so they stay aligned
    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            {pgc_s1, pgc_s2, pgc_s3, pgd_s1, pgd_s2} <= 5'h00;
            {master_clear_pin_s1, master_clear_pin_s2, erq_s1, erq_s2, erq_s3, llm_s1, llm_s2} <= 7'h00;
        end else begin
            {pgc_s1, pgc_s2, pgc_s3} <= {prog_clock_pin, pgc_s1, pgc_s2};
            {pgd_s1, pgd_s2} <= {prog_data_in, pgd_s1};
            {master_clear_pin_s1, master_clear_pin_s2} <= {master_clear_pin, master_clear_pin_s1};
            {erq_s1, erq_s2, erq_s3} <= {bulk_erase_req, erq_s1, erq_s2};
            {llm_s1, llm_s2} <= {low_level_mode, llm_s1};
        end
    end

    wire pgc_fall  = pgc_s3 & ~pgc_s2;
    wire erase_hit = erq_s2 & ~erq_s3 & llm_s2;

    // ==========================================================
    // nonvolatile store and the copies latched at reset release
    reg [15:0] nv1_q, nv2_q, act1_q, act2_q;
    reg        loaded_q;
    reg        cfg_we_q, cfg_hit;
    reg [15:0] cfg_sel_q, cfg_dat_q;

    function [15:0] merge_byte;
        input [15:0] old;
        input [15:0] dat;
        begin
            merge_byte = dat[`CFG_HI_BYTE_BIT] ? {dat[7:0], old[7:0]} : {old[15:8], dat[7:0]};
        end
    endfunction

    wire [15:0] nv1_new = merge_byte(nv1_q, cfg_dat_q);
    // protect bits only move toward protected through a write
    wire [15:0] nv1_wr  = {nv1_new[15:14],
                           nv1_new[`CW1_RD_PROT_BIT] & nv1_q[`CW1_RD_PROT_BIT],
                           nv1_new[`CW1_WR_PROT_BIT] & nv1_q[`CW1_WR_PROT_BIT],
                           nv1_new[11:0]};

    always @(posedge sys_clk or negedge nv_i_n) begin
        if (!nv_i_n) begin
            nv1_q <= `CW_ERASED;
            nv2_q <= `CW_ERASED;
        end else if (erase_hit) begin
            nv1_q <= `CW_ERASED;
            nv2_q <= `CW_ERASED;
        end else if (cfg_we_q) begin
            if (cfg_sel_q == `CFG1_ADDR)
                nv1_q <= nv1_wr;
            else if (cfg_sel_q == `CFG2_ADDR)
                nv2_q <= merge_byte(nv2_q, cfg_dat_q);
        end
    end

    // writes land in the store only; fields follow at the next reset
    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            act1_q   <= `CW_ERASED;
            act2_q   <= `CW_ERASED;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            act1_q   <= nv1_q;
            act2_q   <= nv2_q;
            loaded_q <= 1'b1;
        end
    end

    wire wr_prot = ~act1_q[`CW1_WR_PROT_BIT];
    wire rd_prot = ~act1_q[`CW1_RD_PROT_BIT];

    // ==========================================================
    // command engine
    reg [3:0]  st_q;
    reg [15:0] sh_q, addr_q, cnt_q, mem_addr_q, mem_wdata_q;
    reg [3:0]  bit_q, op_q;
    reg [11:0] len_q, widx_q, left_q;
    reg        fail_q, vfy_q, mem_we_q, oe_q, out_q;
    wire [15:0] word_in = {sh_q[14:0], pgd_s2};
    wire        known   = (op_q == `OP_SANITY) | (op_q == `OP_MEM_READ) |
                          (op_q == `OP_ROW_PROG) | (op_q == `OP_CFG_WRITE);
    wire [3:0]  status  = ~known ? `RSP_NACK : (fail_q ? `RSP_FAIL : `RSP_PASS);
    // config words are readable even under read protection
    wire [15:0] rd_word = (addr_q == `CFG1_ADDR) ? nv1_q :
                          (addr_q == `CFG2_ADDR) ? nv2_q :
                          (rd_prot ? 16'h0000 : mem_rdata);

    always @* begin
        cfg_hit = 1'b0;
        if ((st_q == ST_RX) & pgc_fall & (bit_q == 4'hF) & (op_q == `OP_CFG_WRITE) &
            (widx_q == 12'h002))
            cfg_hit = 1'b1;
    end

    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_q <= ST_RX;
            {sh_q, addr_q, cnt_q, mem_addr_q, mem_wdata_q} <= {5{16'h0000}};
            {bit_q, op_q} <= 8'h00;
            {len_q, widx_q, left_q} <= {3{12'h000}};
            {fail_q, vfy_q, mem_we_q, oe_q, out_q, cfg_we_q} <= 6'h00;
            {cfg_sel_q, cfg_dat_q} <= {2{16'h0000}};
        end else begin
            mem_we_q <= 1'b0;
            vfy_q    <= mem_we_q;
            cfg_we_q <= cfg_hit; // data word lands first
            // read-back check one cycle after each row word write
            if (vfy_q & (rd_word != mem_wdata_q))
                fail_q <= 1'b1;
            if (!master_clear_pin_s2) begin
                st_q   <= ST_RX;
                oe_q   <= 1'b0;
                bit_q  <= 4'h0;
                widx_q <= 12'h000;
            end else case (st_q)
                ST_RX: begin
                    oe_q <= 1'b0;
                    if (pgc_fall) begin
                        sh_q  <= word_in;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'hF) begin
                            widx_q <= widx_q + 12'h001;
                            if (widx_q == 12'h000) begin
                                op_q   <= word_in[15:12];
                                len_q  <= word_in[11:0];
                                fail_q <= 1'b0;
                                if (word_in[11:0] <= 12'h001)
                                    st_q <= ST_BUSY;
                            end else begin
                                if (widx_q == 12'h001)
                                    addr_q <= word_in;
                                if ((widx_q == 12'h001) & (op_q == `OP_MEM_READ))
                                    cnt_q <= word_in;
                                if ((widx_q == 12'h002) & (op_q == `OP_MEM_READ))
                                    addr_q <= word_in;
                                if ((widx_q == 12'h001) & (op_q == `OP_CFG_WRITE))
                                    cfg_sel_q <= word_in;
                                if ((widx_q == 12'h002) & (op_q == `OP_CFG_WRITE))
                                    cfg_dat_q <= word_in;
                                if ((widx_q >= 12'h002) & (op_q == `OP_ROW_PROG)) begin
                                    addr_q      <= addr_q + 16'h0001;
                                    mem_addr_q  <= addr_q;
                                    mem_wdata_q <= word_in;
                                    mem_we_q    <= ~wr_prot;
                                    if (wr_prot | rd_prot)
                                        fail_q <= 1'b1;
                                end
                                if (widx_q == len_q - 12'h001)
                                    st_q <= ST_BUSY;
                            end
                        end
                    end
                end
                ST_BUSY: begin
                    // a few cycles of processing shown as a high line
                    oe_q   <= 1'b1;
                    out_q  <= 1'b1;
                    widx_q <= widx_q + 12'h001;
                    if (widx_q >= BUSY_CYC[11:0] + len_q) begin
                        st_q   <= ST_READY;
                        cnt_q  <= 16'h0000;
                        left_q <= ((op_q == `OP_MEM_READ) & known) ? cnt_q[11:0] : 12'h000;
                    end
                end
                ST_READY: begin
                    out_q      <= 1'b0;
                    cnt_q      <= cnt_q + 16'h0001;
                    mem_addr_q <= addr_q;
                    if (cnt_q == READY_CYC - 16'h0001) begin
                        st_q  <= ST_TX;
                        bit_q <= 4'h0;
                        sh_q  <= {status, op_q, 8'h00};
                        out_q <= status[3];
                    end
                end
                ST_TX: begin
                    mem_addr_q <= addr_q;
                    if (pgc_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'hF) begin
                            if (left_q == 12'h000) begin
                                st_q   <= ST_RX;
                                oe_q   <= 1'b0;
                                widx_q <= 12'h000;
                            end else begin
                                left_q <= left_q - 12'h001;
                                sh_q   <= rd_word;
                                out_q  <= rd_word[15];
                                addr_q <= addr_q + 16'h0001;
                            end
                        end else begin
                            sh_q  <= {sh_q[14:0], 1'b0};
                            out_q <= sh_q[14];
                        end
                    end
                end
                default: st_q <= ST_RX;
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign prog_data_out   = out_q;
    assign prog_data_oe    = oe_q;
    assign mem_addr        = mem_addr_q;
    assign mem_wdata       = mem_wdata_q;
    assign mem_we          = mem_we_q;
    assign config_word_one = act1_q;
    assign config_word_two = act2_q;

    cfg_fields u_fields (
        .clk                     (sys_clk),
        .rst_i_n                 (rst_i_n),
        .cw1                     (act1_q),
        .cw2                     (act2_q),
        .remap_unlocked          (remap_unlocked),
        .remap_lock_set          (remap_lock_set),
        .remap_lock_clear        (remap_lock_clear),
        .emulation_pin_pair      (emulation_pin_pair),
        .dbg_pair_reserved       (dbg_pair_reserved),
        .two_speed_startup_en    (two_speed_startup_en),
        .osc_pin_clock_out       (osc_pin_clock_out),
        .osc_pin_gpio            (osc_pin_gpio),
        .sec_osc_high_drive      (sec_osc_high_drive),
        .sec_osc_low_power       (sec_osc_low_power),
        .sec_osc_reserved        (sec_osc_reserved),
        .primary_osc_mode        (primary_osc_mode),
        .wdog_div_128            (wdog_div_128),
        .wdog_window_mode        (wdog_window_mode),
        .wdog_window_invalid     (wdog_window_invalid),
        .regulator_fast_wake     (regulator_fast_wake),
        .regulator_wake_reserved (regulator_wake_reserved),
        .remap_locked            (remap_locked),
        .remap_write_en          (remap_write_en)
    );
endmodule // prog_exec

// File: prog_exec_chk.sv
// checker: config decode, protection and link turnaround of prog_exec
`timescale 1ns/1ps
module prog_exec_chk (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        prog_data_out,
    input wire        prog_data_oe,
    input wire        mem_we,
    input wire        remap_lock_set,
    input wire        remap_unlocked,
    input wire        remap_locked,
    input wire [15:0] config_word_one,
    input wire [15:0] config_word_two,
    input wire [2:0]  emulation_pin_pair,
    input wire        two_speed_startup_en,
    input wire        sec_osc_high_drive,
    input wire [3:0]  primary_osc_mode,
    input wire        wdog_div_128,
    input wire        wdog_window_mode,
    input wire        regulator_fast_wake
);
    wire [15:0] w1 = config_word_one;
    wire [15:0] w2 = config_word_two;
    reg  [3:0]  up_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // cycles since reset release; saturates so the load cycle is excluded
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    sequence busy_s; prog_data_oe && prog_data_out; endsequence
    sequence ready_s; prog_data_oe && !prog_data_out; endsequence
    pair_decode_a: assert property (
        emulation_pin_pair == {w1[9:8] == 2'h1, w1[9:8] == 2'h2, w1[9:8] == 2'h3}) else $error("debug pair decode");
    two_speed_a: assert property (two_speed_startup_en == w2[15]) else $error("two speed bit");
    remap_once_a: assert property (
        up_q > 4'h1 && remap_unlocked && remap_lock_set || (remap_locked && w2[4]) |=> remap_locked)
        else $error("remap lock dropped");
    sosc_drive_a: assert property (sec_osc_high_drive == (w2[12:11] == 2'h3)) else $error("sosc drive");
    posc_mode_a: assert property (
        primary_osc_mode == {w2[1:0] == 2'h3, w2[1:0] == 2'h2, w2[1:0] == 2'h1, w2[1:0] == 2'h0}) else $error("posc mode");
    wdog_div_a: assert property (wdog_div_128 == w1[4]) else $error("wdog divider");
    wdog_window_a: assert property (wdog_window_mode == (!w1[6] && w1[7])) else $error("wdog window");
    wake_sel_a: assert property (regulator_fast_wake == (w2[14:13] == 2'h1)) else $error("wake select");
    write_block_a: assert property (!w1[12] |-> !mem_we) else $error("write under protect");
    cfg_hold_a: assert property (up_q == 4'hF |-> $stable(w1) && $stable(w2)) else $error("config moved");
    busy_first_a: assert property ($rose(prog_data_oe) |-> busy_s [*4]) else $error("busy too short");
    ready_low_a: assert property (busy_s ##1 ready_s |-> ready_s [*8]) else $error("ready too short");
endmodule // prog_exec_chk
bind prog_exec prog_exec_chk prog_exec_chk_i (.sys_clk, .rst_n, .prog_data_out, .prog_data_oe, .mem_we,
    .remap_lock_set, .remap_locked, .config_word_one, .config_word_two, .emulation_pin_pair, .two_speed_startup_en,
    .sec_osc_high_drive, .primary_osc_mode, .wdog_div_128, .wdog_window_mode, .regulator_fast_wake, .remap_unlocked);

// File: prog_host.sv
// programmer model: master of the link clock and data line
`timescale 1ns/1ps
module prog_host (
    input  wire sys_clk,
    input  wire prog_data_out,
    input  wire prog_data_oe,
    output reg  prog_clock_pin,
    output wire prog_data_in
);
    reg        drv = 1'b0;
    reg        bit_q = 1'b0;
    reg [15:0] rx_word;
    event      got;
    // ==========
    // a released line shows the inverse of the last bit, never a stale copy
    assign prog_data_in = prog_data_oe ? prog_data_out : (drv ? bit_q : ~bit_q);
    initial prog_clock_pin = 1'b0; // clock stands low between frames
    // one word msb first, changed at the rise, held over the fall
    task send(input [15:0] w);
        integer i;
        begin
            drv = 1'b1;
            for (i = 15; i >= 0; i = i - 1) begin
                prog_clock_pin = 1'b1;
                bit_q = w[i];
                #160 prog_clock_pin = 1'b0;
                #160;
            end
            drv = 1'b0; // line handed over after each word
        end
    endtask
    // wait for ready low, give it 23 us, then clock out n words
    task recv(input integer n);
        integer i, t;
        begin
            for (t = 0; t < 9000 && !(prog_data_oe && !prog_data_out); t = t + 1)
                @(negedge sys_clk);
            #23000;
            repeat (n) begin
                for (i = 15; i >= 0; i = i - 1) begin
                    prog_clock_pin = 1'b1;
                    #160 rx_word[i] = prog_data_in;
                    prog_clock_pin = 1'b0;
                    #160;
                end
                -> got;
            end
        end
    endtask
endmodule // prog_host

// File: config_word_program_and_protect_bench.sv
// bench: command link, config store, protection and reset timing of prog_exec
`timescale 1ns/1ps
module config_word_program_and_protect_bench;
    reg         sys_clk, rst_n, nv_por_n, master_clear_pin, low_level_mode, bulk_erase_req;
    reg         remap_unlocked, remap_lock_set, remap_lock_clear;
    reg  [15:0] mem [0:255];
    reg  [15:0] expq [$];
    reg  [31:0] seed;
    reg  [15:0] v, cw2;
    integer     n_fail, n_compared;
    wire        prog_clock_pin, prog_data_in, prog_data_out, prog_data_oe, mem_we;
    wire [15:0] mem_addr, mem_wdata;
    wire [15:0] mem_rdata = mem[mem_addr[7:0]];
    prog_exec prog_exec_i (.sys_clk, .rst_n, .nv_por_n, .master_clear_pin, .prog_clock_pin, .prog_data_in,
        .prog_data_out, .prog_data_oe, .low_level_mode, .bulk_erase_req, .mem_addr, .mem_wdata, .mem_we, .mem_rdata,
        .remap_unlocked, .remap_lock_set, .remap_lock_clear, .config_word_one(), .config_word_two(),
        .emulation_pin_pair(), .dbg_pair_reserved(), .two_speed_startup_en(), .osc_pin_clock_out(), .osc_pin_gpio(),
        .sec_osc_high_drive(), .sec_osc_low_power(), .sec_osc_reserved(), .primary_osc_mode(), .wdog_div_128(),
        .wdog_window_mode(), .wdog_window_invalid(), .regulator_fast_wake(), .regulator_wake_reserved(),
        .remap_locked(), .remap_write_en());
    prog_host prog_host_i (.sys_clk, .prog_data_out, .prog_data_oe, .prog_clock_pin, .prog_data_in);
    // ==========
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
    // random remap traffic
    always @(negedge sys_clk) {remap_unlocked, remap_lock_set, remap_lock_clear} <= 3'($random(seed));
    // each response word is checked against the oldest note
    always @(prog_host_i.got) begin
        n_compared = n_compared + 1;
        v = expq.pop_front();
        if (prog_host_i.rx_word !== v) begin
            n_fail = n_fail + 1;
            $display("wrong value response expected %h seen %h", v, prog_host_i.rx_word);
        end
    end
    task complete_run;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // header length decides how many words go out; n response words come back
    task cmd(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] e0, input [15:0] e1, input integer n);
        begin
            @(negedge sys_clk);
            expq.push_back(e0);
            if (n > 1) expq.push_back(e1);
            prog_host_i.send(a);
            if (a[11:0] > 12'h1) prog_host_i.send(b);
            if (a[11:0] > 12'h2) prog_host_i.send(c);
            prog_host_i.recv(n);
            repeat (20) @(negedge sys_clk);
        end
    endtask
    task reboot;
        begin
            rst_n = 1'b0;
            repeat (4) @(negedge sys_clk);
            rst_n = 1'b1;
            repeat (12) @(negedge sys_clk);
        end
    endtask
    task erase(input m);
        begin
            low_level_mode = m;
            repeat (4) @(negedge sys_clk);
            bulk_erase_req = 1'b1;
            repeat (6) @(negedge sys_clk);
            {bulk_erase_req, low_level_mode} = 2'h0;
            repeat (4) @(negedge sys_clk);
        end
    endtask
    initial begin
        #3000000;
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        seed = 32'h3ACA6B98;
        {n_fail, n_compared} = 0;
        {rst_n, nv_por_n, master_clear_pin, low_level_mode, bulk_erase_req} = 5'h0;
        repeat (4) @(negedge sys_clk);
        {rst_n, nv_por_n, master_clear_pin} = 3'h7;
        repeat (12) @(negedge sys_clk);
        cw2 = 16'($random(seed)) | 16'h2800; // reserved patterns avoided
        cmd(16'h0001, 16'h0000, 16'h0000, 16'h1000, 16'h0000, 1);
        cmd(16'h3001, 16'h0000, 16'h0000, 16'h3300, 16'h0000, 1);
        cmd(16'h6003, 16'hFFFF, {8'h01, cw2[15:8]}, 16'h1600, 16'h0000, 1);
        cmd(16'h6003, 16'hFFFF, {8'h00, cw2[7:0]}, 16'h1600, 16'h0000, 1);
        cmd(16'h2003, 16'h0001, 16'hFFFF, 16'h1200, cw2, 2);
        cmd(16'h5003, 16'h0010, cw2, 16'h1500, 16'h0000, 1);
        cmd(16'h2003, 16'h0001, 16'h0010, 16'h1200, cw2, 2);
        cmd(16'h6003, 16'hFFFE, 16'h01EF, 16'h1600, 16'h0000, 1);
        reboot;
        cmd(16'h5003, 16'h0011, cw2, 16'h2500, 16'h0000, 1);
        cmd(16'h6003, 16'hFFFE, 16'h01FF, 16'h1600, 16'h0000, 1);
        erase(1'b0);
        cmd(16'h2003, 16'h0001, 16'hFFFE, 16'h1200, 16'hEFFF, 2);
        erase(1'b1);
        cmd(16'h2003, 16'h0001, 16'hFFFE, 16'h1200, 16'hFFFF, 2);
        cmd(16'h6003, 16'hFFFE, 16'h01DF, 16'h1600, 16'h0000, 1);
        reboot;
        cmd(16'h2003, 16'h0001, 16'h0010, 16'h1200, 16'h0000, 2);
        cmd(16'h5003, 16'h0010, cw2, 16'h2500, 16'h0000, 1);
        prog_host_i.send(16'h0001);
        prog_host_i.recv(0);
        @(negedge sys_clk) master_clear_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        n_compared = n_compared + 1;
        if (prog_data_oe !== 1'b0) begin
            n_fail = n_fail + 1;
            $display("wrong value oe expected 0 seen %b", prog_data_oe);
        end
        master_clear_pin = 1'b1;
        cmd(16'h0001, 16'h0000, 16'h0000, 16'h1000, 16'h0000, 1);
        complete_run;
    end
endmodule // config_word_program_and_protect_bench
